// ==== hw/prlr_defs.svh ====
// offsets, field positions, masks and reset values of the priority level slice
`ifndef PRLR_DEFS_SVH
`define PRLR_DEFS_SVH

// register indices as printed, byte address is four times the index
`define PRLR_IDX_SET3 3
`define PRLR_IDX_SET4 4
`define PRLR_IDX_SET5 5
`define PRLR_IDX_SET6 6
`define PRLR_ADDR_SET3 12'h00C
`define PRLR_ADDR_SET4 12'h010
`define PRLR_ADDR_SET5 12'h014
`define PRLR_ADDR_SET6 12'h018

// reset value of every priority register
`define PRLR_RESET_VALUE 16'h0000

// writable bits of each register, everything else reads zero
`define PRLR_MASK_SET3 16'h03FC
`define PRLR_MASK_SET4 16'hFC3F
`define PRLR_MASK_SET5 16'hFF3F
`define PRLR_MASK_SET6 16'hFC00

// low bit of each field, register 3
`define PRLR_POS_CAN_MSG_BUFFER 8
`define PRLR_POS_CAN_WAKEUP 6
`define PRLR_POS_CAN_ERROR 4
`define PRLR_POS_CAN_BUS_OFF 2
// register 4
`define PRLR_POS_SP0_RX_FULL 14
`define PRLR_POS_SP1_TX_EMPTY 12
`define PRLR_POS_SP1_RX_FULL 10
`define PRLR_POS_PORT_A 4
`define PRLR_POS_PORT_B 2
`define PRLR_POS_PORT_C 0
// register 5
`define PRLR_POS_DEC1_INDEX 14
`define PRLR_POS_DEC1_HOME_WD 12
`define PRLR_POS_UART1_RX_FULL 10
`define PRLR_POS_UART1_RX_ERROR 8
`define PRLR_POS_UART1_TX_IDLE 4
`define PRLR_POS_UART1_TX_EMPTY 2
`define PRLR_POS_SP0_TX_EMPTY 0
// register 6
`define PRLR_POS_TIMER_C_CH0 14
`define PRLR_POS_TIMER_D_CH3 12
`define PRLR_POS_TIMER_D_CH2 10

// source numbering on the level output
`define PRLR_SRC_CAN_MSG_BUFFER 0
`define PRLR_SRC_CAN_BUS_OFF 3
`define PRLR_SRC_SP0_RX_FULL 4
`define PRLR_SRC_PORT_C 9
`define PRLR_SRC_DEC1_INDEX 10
`define PRLR_SRC_SP0_TX_EMPTY 16
`define PRLR_SRC_TIMER_C_CH0 17
`define PRLR_SRC_TIMER_D_CH2 19
`define PRLR_NUM_SOURCES 20

// field code and level ceiling
`define PRLR_FIELD_DISABLED 2'h0
`define PRLR_LEVEL_MAX 2'h2

`endif

// ==== hw/prlr_pkg.sv ====
// types shared by the priority level slice
package prlr_pkg;
    typedef logic [1:0] prlr_priority_level_field_t;

    // one source as seen by the core interrupt logic
    typedef struct packed {
        logic enabled;
        logic [1:0] level;
    } prlr_src_level_t;

    typedef prlr_src_level_t [19:0] prlr_src_levels_t;
    typedef prlr_priority_level_field_t [19:0] prlr_fields_t;
endpackage : prlr_pkg

// ==== hw/prlr_top.sv ====
// priority level register slice with apb slave and decoded level outputs
//
// Behaviour
// [R1] field 00 disables a source; 01, 10, 11 select levels 0, 1, 2
// [R2] all priority fields come out of reset as 00, every source disabled
// [R3] no source is ever delivered above level 2
// [R4] reserved bits read zero and ignore writes
// [R5] register 3 holds can message buffer, wake-up, error, bus-off fields; bits 15-10 and 1-0 reserved
// [R6] register 4 holds serial rx/tx fields, reserved 9-6, ports a, b, c at bottom
// [R7] register 5 holds decoder-1, uart-1 and serial-0 transmit fields; bits 7-6 reserved
// [R8] register 6 upper bits hold timer c ch0, timer d ch3, timer d ch2
// [R9] can priority register sits at index 3, all sixteen bits reset to zero
// [R10] decoded levels reach the core the cycle after the write; 00 masks source
`timescale 1ns/1ps
`include "prlr_defs.svh"

module prlr_top
    import prlr_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // levels to the core interrupt logic
    output prlr_src_levels_t src_levels
);

    logic [15:0] set3;
    logic [15:0] set4;
    logic [15:0] set5;
    logic [15:0] set6;
    logic [15:0] next_set3;
    logic [15:0] next_set4;
    logic [15:0] next_set5;
    logic [15:0] next_set6;
    logic [15:0] lane_mask;
    logic [15:0] read_value;
    logic addr_hit;
    logic setup_phase;
    logic write_done;

    // two-bit field to core level
    function automatic prlr_src_level_t decode_field(input prlr_priority_level_field_t f);
        prlr_src_level_t r;
        r.enabled = (f != `PRLR_FIELD_DISABLED);
        r.level = r.enabled ? 2'(f - 2'h1) : 2'h0;
        return r;
    endfunction : decode_field

    // merge a write into one register, keeping unwritten lanes and reserved bits
    function automatic logic [15:0] merge_write(input logic [15:0] old, input logic [15:0] wdata,
            input logic [15:0] lanes, input logic [15:0] mask);
        return (old & ~(lanes & mask)) | (wdata & lanes & mask);
    endfunction : merge_write

    // unpack the four registers into the twenty source fields
    function automatic prlr_fields_t gather_fields(input logic [15:0] r3, input logic [15:0] r4,
            input logic [15:0] r5, input logic [15:0] r6);
        prlr_fields_t f;
        f[0] = r3[`PRLR_POS_CAN_MSG_BUFFER +: 2];
        f[1] = r3[`PRLR_POS_CAN_WAKEUP +: 2];
        f[2] = r3[`PRLR_POS_CAN_ERROR +: 2];
        f[3] = r3[`PRLR_POS_CAN_BUS_OFF +: 2];
        f[4] = r4[`PRLR_POS_SP0_RX_FULL +: 2];
        f[5] = r4[`PRLR_POS_SP1_TX_EMPTY +: 2];
        f[6] = r4[`PRLR_POS_SP1_RX_FULL +: 2];
        f[7] = r4[`PRLR_POS_PORT_A +: 2];
        f[8] = r4[`PRLR_POS_PORT_B +: 2];
        f[9] = r4[`PRLR_POS_PORT_C +: 2];
        f[10] = r5[`PRLR_POS_DEC1_INDEX +: 2];
        f[11] = r5[`PRLR_POS_DEC1_HOME_WD +: 2];
        f[12] = r5[`PRLR_POS_UART1_RX_FULL +: 2];
        f[13] = r5[`PRLR_POS_UART1_RX_ERROR +: 2];
        f[14] = r5[`PRLR_POS_UART1_TX_IDLE +: 2];
        f[15] = r5[`PRLR_POS_UART1_TX_EMPTY +: 2];
        f[16] = r5[`PRLR_POS_SP0_TX_EMPTY +: 2];
        f[17] = r6[`PRLR_POS_TIMER_C_CH0 +: 2];
        f[18] = r6[`PRLR_POS_TIMER_D_CH3 +: 2];
        f[19] = r6[`PRLR_POS_TIMER_D_CH2 +: 2];
        return f;
    endfunction : gather_fields

    function automatic prlr_src_levels_t decode_all(input prlr_fields_t f);
        prlr_src_levels_t l;
        for (int i = 0; i < `PRLR_NUM_SOURCES; i++) begin
            l[i] = decode_field(f[i]);
        end
        return l;
    endfunction : decode_all

    assign setup_phase = psel && !penable;
    assign write_done = psel && penable && pwrite && pready;
    // only the low two byte lanes carry register bits
    assign lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

    always_comb begin
        addr_hit = 1'b1;
        read_value = 16'h0000;
        case (paddr)
            `PRLR_ADDR_SET3: read_value = set3 & `PRLR_MASK_SET3; // [R9] [R4]
            `PRLR_ADDR_SET4: read_value = set4 & `PRLR_MASK_SET4; // [R4]
            `PRLR_ADDR_SET5: read_value = set5 & `PRLR_MASK_SET5; // [R4]
            `PRLR_ADDR_SET6: read_value = set6 & `PRLR_MASK_SET6; // [R4]
            default: addr_hit = 1'b0;
        endcase
    end

    always_comb begin
        next_set3 = set3;
        next_set4 = set4;
        next_set5 = set5;
        next_set6 = set6;
        if (write_done) begin
            case (paddr)
                `PRLR_ADDR_SET3: begin
                    next_set3 = merge_write(set3, pwdata[15:0], lane_mask, `PRLR_MASK_SET3); // [R5]
                end
                `PRLR_ADDR_SET4: begin
                    next_set4 = merge_write(set4, pwdata[15:0], lane_mask, `PRLR_MASK_SET4); // [R6]
                end
                `PRLR_ADDR_SET5: begin
                    next_set5 = merge_write(set5, pwdata[15:0], lane_mask, `PRLR_MASK_SET5); // [R7]
                end
                `PRLR_ADDR_SET6: begin
                    next_set6 = merge_write(set6, pwdata[15:0], lane_mask, `PRLR_MASK_SET6); // [R8]
                end
                default: begin
                end
            endcase
        end
    end

    // register storage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            set3 <= `PRLR_RESET_VALUE; // [R2] [R9]
            set4 <= `PRLR_RESET_VALUE; // [R2]
            set5 <= `PRLR_RESET_VALUE; // [R2]
            set6 <= `PRLR_RESET_VALUE; // [R2]
        end else begin
            set3 <= next_set3;
            set4 <= next_set4;
            set5 <= next_set5;
            set6 <= next_set6;
        end
    end

    // decoded levels load from the same next values so they follow the write by one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_levels <= '0; // [R2]
        end else begin
            src_levels <= decode_all(gather_fields(next_set3, next_set4, next_set5, next_set6)); // [R1] [R3] [R10]
        end
    end

    // apb answer: zero wait states, read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup_phase) begin
            prdata <= pwrite ? 32'h0000_0000 : {16'h0000, read_value};
            pslverr <= !addr_hit;
        end
    end

    // assertions
    logic any_write;
    prlr_fields_t cur_fields;
    assign cur_fields = gather_fields(set3, set4, set5, set6);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            any_write <= 1'b0;
        end else if (write_done) begin
            any_write <= 1'b1;
        end
    end

    sequence wr_seq(logic [11:0] a);
        psel && penable && pwrite && pready && paddr == a && pstrb[1:0] == 2'h3;
    endsequence

    sequence rd_seq(logic [11:0] a);
        psel && !penable && !pwrite && paddr == a ##1 psel && penable;
    endsequence

    sequence wr_lane_off_seq(logic [11:0] a, int lane);
        psel && penable && pwrite && pready && paddr == a && !pstrb[lane];
    endsequence

    // whole-vector checks over all twenty sources
    logic any_level_three;
    logic any_masked_level;
    logic any_enable_mismatch;

    always_comb begin
        any_level_three = 1'b0;
        any_masked_level = 1'b0;
        any_enable_mismatch = 1'b0;
        for (int i = 0; i < `PRLR_NUM_SOURCES; i++) begin
            if (src_levels[i].level > `PRLR_LEVEL_MAX) begin
                any_level_three = 1'b1;
            end
            if (!src_levels[i].enabled && src_levels[i].level != 2'h0) begin
                any_masked_level = 1'b1;
            end
            if (src_levels[i].enabled != (cur_fields[i] != `PRLR_FIELD_DISABLED)) begin
                any_enable_mismatch = 1'b1;
            end
        end
    end

    disabled_means_zero_a: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
        (!src_levels[`PRLR_SRC_PORT_C].enabled) |-> src_levels[`PRLR_SRC_PORT_C].level == 2'h0)
        else $error("disabled source shows a nonzero level");

    reset_all_disabled_a: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
        !any_write |-> (src_levels == '0 && set3 == 16'h0000 && set4 == 16'h0000))
        else $error("source enabled before any write");

    level_ceiling_a: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
        src_levels[`PRLR_SRC_TIMER_D_CH2].level <= `PRLR_LEVEL_MAX
        && src_levels[`PRLR_SRC_CAN_MSG_BUFFER].level <= `PRLR_LEVEL_MAX)
        else $error("level above two delivered");

    reserved_read_zero_a: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
        rd_seq(`PRLR_ADDR_SET4) |-> (prdata & ~{16'h0000, `PRLR_MASK_SET4}) == 32'h0)
        else $error("reserved bits read nonzero");

    can_bus_off_map_a: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
        wr_seq(`PRLR_ADDR_SET3) ##1 1'b1 |->
        src_levels[`PRLR_SRC_CAN_BUS_OFF] == decode_field($past(pwdata[3:2])))
        else $error("can bus-off field misplaced");

    serial_rx_map_a: assert property (@(posedge pclk) disable iff (!presetn) // [R6] [R10]
        wr_seq(`PRLR_ADDR_SET4) |=>
        src_levels[`PRLR_SRC_SP0_RX_FULL] == decode_field($past(pwdata[15:14])))
        else $error("serial receive field not delivered next cycle");

    decoder_index_map_a: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
        wr_seq(`PRLR_ADDR_SET5) |=>
        src_levels[`PRLR_SRC_DEC1_INDEX] == decode_field($past(pwdata[15:14]))
        && src_levels[`PRLR_SRC_SP0_TX_EMPTY] == decode_field($past(pwdata[1:0])))
        else $error("register five fields misplaced");

    timer_map_a: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
        wr_seq(`PRLR_ADDR_SET6) |=>
        src_levels[`PRLR_SRC_TIMER_C_CH0] == decode_field($past(pwdata[15:14]))
        && set6[9:0] == 10'h000)
        else $error("register six fields misplaced");

    can_read_back_a: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
        rd_seq(`PRLR_ADDR_SET3) |-> prdata == {16'h0000, set3 & `PRLR_MASK_SET3} && !pslverr)
        else $error("register three read back wrong");

    outputs_track_fields_a: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
        src_levels == decode_all(cur_fields))
        else $error("decoded levels out of step with fields");

    reset_regs_zero_a: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
        !any_write |-> set5 == 16'h0000 && set6 == 16'h0000)
        else $error("register five or six left reset before any write");

    can_upper_map_a: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
        wr_seq(`PRLR_ADDR_SET3) |=>
        src_levels[`PRLR_SRC_CAN_MSG_BUFFER] == decode_field($past(pwdata[9:8]))
        && src_levels[`PRLR_SRC_CAN_MSG_BUFFER + 1] == decode_field($past(pwdata[7:6]))
        && src_levels[`PRLR_SRC_CAN_MSG_BUFFER + 2] == decode_field($past(pwdata[5:4])))
        else $error("can upper fields misplaced");

    can_reserved_kept_a: assert property (@(posedge pclk) disable iff (!presetn) // [R4] [R5]
        wr_seq(`PRLR_ADDR_SET3) |=> set3[1:0] == 2'h0 && set3[15:10] == 6'h00)
        else $error("register three reserved bits took a write");

    serial_port_map_a: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
        wr_seq(`PRLR_ADDR_SET4) |=>
        src_levels[`PRLR_SRC_SP0_RX_FULL + 1] == decode_field($past(pwdata[13:12]))
        && src_levels[`PRLR_SRC_SP0_RX_FULL + 2] == decode_field($past(pwdata[11:10]))
        && src_levels[`PRLR_SRC_PORT_C - 2] == decode_field($past(pwdata[5:4]))
        && src_levels[`PRLR_SRC_PORT_C - 1] == decode_field($past(pwdata[3:2]))
        && src_levels[`PRLR_SRC_PORT_C] == decode_field($past(pwdata[1:0])))
        else $error("register four fields misplaced");

    reg_four_reserved_a: assert property (@(posedge pclk) disable iff (!presetn) // [R4] [R6]
        wr_seq(`PRLR_ADDR_SET4) |=> set4[9:6] == 4'h0)
        else $error("register four reserved bits took a write");

    uart_map_a: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
        wr_seq(`PRLR_ADDR_SET5) |=>
        src_levels[`PRLR_SRC_DEC1_INDEX + 1] == decode_field($past(pwdata[13:12]))
        && src_levels[`PRLR_SRC_DEC1_INDEX + 2] == decode_field($past(pwdata[11:10]))
        && src_levels[`PRLR_SRC_DEC1_INDEX + 3] == decode_field($past(pwdata[9:8]))
        && src_levels[`PRLR_SRC_DEC1_INDEX + 4] == decode_field($past(pwdata[5:4]))
        && src_levels[`PRLR_SRC_DEC1_INDEX + 5] == decode_field($past(pwdata[3:2])))
        else $error("uart one fields misplaced");

    reg_five_reserved_a: assert property (@(posedge pclk) disable iff (!presetn) // [R4] [R7]
        wr_seq(`PRLR_ADDR_SET5) |=> set5[7:6] == 2'h0)
        else $error("register five reserved bits took a write");

    timer_d_map_a: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
        wr_seq(`PRLR_ADDR_SET6) |=>
        src_levels[`PRLR_SRC_TIMER_C_CH0 + 1] == decode_field($past(pwdata[13:12]))
        && src_levels[`PRLR_SRC_TIMER_D_CH2] == decode_field($past(pwdata[11:10])))
        else $error("timer d fields misplaced");

    reg_five_read_a: assert property (@(posedge pclk) disable iff (!presetn) // [R4] [R7]
        rd_seq(`PRLR_ADDR_SET5) |-> prdata == {16'h0000, set5 & `PRLR_MASK_SET5} && !pslverr)
        else $error("register five read back wrong");

    reg_six_read_a: assert property (@(posedge pclk) disable iff (!presetn) // [R4] [R8]
        rd_seq(`PRLR_ADDR_SET6) |-> prdata == {16'h0000, set6 & `PRLR_MASK_SET6} && !pslverr)
        else $error("register six read back wrong");

    low_lane_kept_a: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
        wr_lane_off_seq(`PRLR_ADDR_SET4, 0) |=> set4[7:0] == $past(set4[7:0]))
        else $error("register four low byte changed without its strobe");

    high_lane_kept_a: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
        wr_lane_off_seq(`PRLR_ADDR_SET5, 1) |=> set5[15:8] == $past(set5[15:8]))
        else $error("register five high byte changed without its strobe");

    levels_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
        !write_done |=> $stable(src_levels))
        else $error("decoded levels moved without a write");

    ceiling_all_a: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
        !any_level_three)
        else $error("some source delivered above level two");

    masked_all_zero_a: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
        !any_masked_level)
        else $error("masked source shows a nonzero level");

    enable_follows_field_a: assert property (@(posedge pclk) disable iff (!presetn) // [R1] [R10]
        !any_enable_mismatch)
        else $error("source enable disagrees with its field");

endmodule : prlr_top

// ==== tb/prlr_core_model.sv ====
// behavioural core interrupt logic consuming the decoded source levels
`timescale 1ns/1ps
`include "prlr_defs.svh"

module prlr_core_model
    import prlr_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // levels from the slice
    input wire prlr_src_levels_t src_levels,
    // sticky flag for a level the core cannot take
    output logic level_fault
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_fault <= 1'b0;
        end else begin
            for (int i = 0; i < `PRLR_NUM_SOURCES; i++) begin
                // core takes only levels 0 to 2, a masked source must show level 0
                if (src_levels[i].enabled && src_levels[i].level > `PRLR_LEVEL_MAX) begin
                    level_fault <= 1'b1;
                end
                if (!src_levels[i].enabled && src_levels[i].level != 2'h0) begin
                    level_fault <= 1'b1;
                end
            end
        end
    end
endmodule : prlr_core_model

// ==== tb/prlr_top_tb.sv ====
// self-checking bench for the priority level slice
`timescale 1ns/1ps
`include "prlr_defs.svh"

module prlr_top_tb
    import prlr_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0] pstrb = 4'h0;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    prlr_src_levels_t src_levels;
    logic level_fault;
    int err_total = 0;
    int n_tests = 0;
    logic [15:0] mirror [3:6];
    logic [32:0] rd_q [$];
    prlr_src_levels_t lvl_q [$];
    logic lvl_due = 1'b0;

    prlr_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .src_levels(src_levels));
    prlr_core_model i_core (.pclk(pclk), .presetn(presetn), .src_levels(src_levels),
        .level_fault(level_fault));

    always #2 pclk = ~pclk;

    function automatic logic [15:0] mask_of(input int idx);
        case (idx)
            3: return `PRLR_MASK_SET3;
            4: return `PRLR_MASK_SET4;
            5: return `PRLR_MASK_SET5;
            6: return `PRLR_MASK_SET6;
            default: return 16'h0000;
        endcase
    endfunction : mask_of

    // sources are numbered by register, then from the top field down
    function automatic prlr_src_levels_t exp_levels();
        prlr_src_levels_t e;
        int s;
        logic [1:0] f;
        logic [15:0] m;
        s = 0;
        e = '0;
        for (int r = 3; r <= 6; r++) begin
            m = mask_of(r);
            for (int p = 14; p >= 0; p -= 2) begin
                if (m[p]) begin
                    f = mirror[r][p+:2];
                    e[s] = (f == 2'h0) ? 3'h0 : {1'b1, 2'(f - 2'h1)};
                    s++;
                end
            end
        end
        return e;
    endfunction : exp_levels

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic cmp_rd(input logic [32:0] e, input logic [32:0] g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("wrong value read response expected %h seen %h", e, g);
        end
    endtask : cmp_rd

    task automatic cmp_lvl(input logic [60:0] e, input logic [60:0] g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("wrong value source levels expected %h seen %h", e, g);
        end
    endtask : cmp_lvl

    // one transfer, entered just after a rising edge; request is not released here
    task automatic apb(input logic wr, input logic [11:0] a, input logic [15:0] d,
                       input logic [3:0] st);
        int idx;
        int k;
        logic hit;
        logic [15:0] m;
        idx = int'(a[11:2]);
        hit = (a[1:0] == 2'h0) && idx >= 3 && idx <= 6;
        if (wr && hit) begin
            m = {{8{st[1]}}, {8{st[0]}}} & mask_of(idx);
            mirror[idx] = (mirror[idx] & ~m) | (d & m);
        end
        if (wr) begin
            lvl_q.push_back(exp_levels());
        end
        // writes answer with zero data; unmapped places answer with an error either way
        rd_q.push_back({!hit, 16'h0000, (hit && !wr) ? mirror[idx] : 16'h0000});
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {16'($urandom), d};
        pstrb <= st;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            err_total++;
            report_and_stop();
        end
    endtask : apb

    task automatic idle();
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : idle

    task automatic reset_dut();
        presetn <= 1'b0;
        for (int r = 3; r <= 6; r++) mirror[r] = 16'h0000;
        repeat (2) @(posedge pclk);
        cmp_lvl({1'b0, exp_levels()}, {level_fault, src_levels});
        presetn <= 1'b1;
        @(posedge pclk);
    endtask : reset_dut

    // watches completed transfers and compares against the oldest note
    always @(posedge pclk) begin
        if (presetn === 1'b1) begin
            if (lvl_due) cmp_lvl({1'b0, lvl_q.pop_front()}, {level_fault, src_levels});
            lvl_due <= (psel & penable & pwrite & pready) === 1'b1;
            if ((psel & penable & pready) === 1'b1) begin
                cmp_rd(rd_q.pop_front(), {pslverr, prdata});
            end
        end else begin
            lvl_due <= 1'b0;
        end
    end

    initial begin
        int r;
        void'($urandom(56));
        reset_dut();
        for (r = 3; r <= 6; r++) apb(1'b0, 12'(r * 4), 16'h0000, 4'hF);
        // all ones first, then each field code down to disabled
        for (int c = 3; c >= 0; c--) begin
            for (r = 3; r <= 6; r++) apb(1'b1, 12'(r * 4), {8{2'(c)}}, 4'hF);
            for (r = 3; r <= 6; r++) apb(1'b0, 12'(r * 4), 16'h0000, 4'hF);
        end
        repeat (24) begin
            r = 3 + int'($urandom % 4);
            apb(1'b1, 12'(r * 4), 16'($urandom), 4'($urandom));
            apb(1'b0, 12'(r * 4), 16'h0000, 4'hF);
        end
        // unmapped places are refused and leave the registers alone
        apb(1'b1, 12'h01C, 16'hFFFF, 4'hF);
        apb(1'b1, 12'h008, 16'hFFFF, 4'hF);
        apb(1'b0, 12'h01C, 16'h0000, 4'hF);
        apb(1'b0, `PRLR_ADDR_SET3, 16'h0000, 4'hF);
        idle();
        reset_dut();
        for (r = 3; r <= 6; r++) apb(1'b0, 12'(r * 4), 16'h0000, 4'hF);
        idle();
        repeat (2) @(posedge pclk);
        report_and_stop();
    end
endmodule : prlr_top_tb
